//--- core/sideband_pkg.sv
// Constants shared by the sideband reset and power-management sequencer.
// Assumes a single 25 MHz core clock and a 32-bit AHB-Lite register port.
package sideband_pkg;

    localparam int          CLK_PERIOD_NS    = 40;
    // Debounce window kept short so sync plus filter fits the tightest skew budget
    localparam int          DEBOUNCE_NS      = 40;
    localparam int          DEBOUNCE_CYCLES  = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          HALT_MIN_NS      = 1000;
    localparam int          HALT_MIN_CYCLES  = (HALT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W            = 8;

    localparam logic [31:0] CTRL_ADDR        = 32'h0000_0000;
    localparam logic [31:0] STATUS_ADDR      = 32'h0000_0004;
    localparam logic [31:0] NP_COUNT_ADDR    = 32'h0000_0008;

    localparam int          CTRL_SW_CHAIN    = 0;
    localparam int          CTRL_SW_SEC      = 1;
    localparam int          CTRL_WAKE        = 2;
    localparam int          CTRL_HOST_MODE   = 3;
    localparam int          CTRL_OD_EN       = 4;
    localparam int          CTRL_BRIDGE      = 5;
    localparam int          CTRL_W           = 6;
    localparam logic [5:0]  CTRL_RESET       = 6'h00;

    localparam int          ST_PG            = 0;
    localparam int          ST_RST_N         = 1;
    localparam int          ST_HALT_N        = 2;
    localparam int          ST_WAKE_N        = 3;
    localparam int          ST_STATE_LSB     = 4;
    localparam int          ST_COLD          = 8;
    localparam int          ST_ORDER_ERR     = 9;
    localparam int          ST_SHORT_HALT    = 10;

    typedef enum logic [1:0] {
        COLD_RESET,
        WARM_RESET,
        HALTED,
        ACTIVE
    } link_state_type;

endpackage

//--- core/sideband_filter.sv
// Two-flop synchroniser followed by a stability debounce for one slow pin.
// Assumes the pin is asynchronous to hclk and may edge slowly.
`timescale 1ns/10ps
module sideband_filter
    import sideband_pkg::*;
#(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin_in,
    output logic      fast_out,
    output logic      clean_out
);

    logic                meta_reg;
    logic                sync_reg;
    logic [CNT_W-1:0]    stable_reg;

    // Only sync_reg reads meta_reg
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_reg <= RESET_VAL;
            sync_reg <= RESET_VAL;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stable_reg <= '0;
            clean_out  <= RESET_VAL;
        end else if (sync_reg == clean_out) begin
            stable_reg <= '0;
        end else if (stable_reg >= CNT_W'(DEBOUNCE_CYCLES)) begin
            stable_reg <= '0;
            clean_out  <= sync_reg;
        end else begin
            stable_reg <= stable_reg + CNT_W'(1);
        end
    end

    assign fast_out = sync_reg;

    AST_FILTER_FOLLOWS_SYNC: assert property (@(posedge hclk) disable iff (!hresetn)
        (clean_out != $past(clean_out)) |-> (clean_out == $past(sync_reg)))
        else $error("Filtered level changed without a synchronised cause");

endmodule

//--- core/np_error_drain.sv
// Tracks outstanding nonposted requests toward the secondary chain and
// answers each with an error response once the secondary reset asserts.
// Assumes issue and done strobes come from logic on hclk.
`timescale 1ns/10ps
module np_error_drain
    import sideband_pkg::*;
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             sec_reset_active,
    input  wire logic             np_issue,
    input  wire logic             np_done,
    output logic                  np_err_rsp,
    output logic [CNT_W-1:0]      np_count
);

    logic accept_issue;

    // New requests are not counted while the secondary is held in reset
    assign accept_issue = np_issue && !sec_reset_active;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            np_count   <= '0;
            np_err_rsp <= 1'b0;
        end else if (sec_reset_active && np_count != '0) begin
            np_count   <= np_count - CNT_W'(1);
            np_err_rsp <= 1'b1;
        end else begin
            np_err_rsp <= 1'b0;
            if (accept_issue && !np_done && np_count != '1) begin
                np_count <= np_count + CNT_W'(1);
            end else if (!accept_issue && np_done && np_count != '0) begin
                np_count <= np_count - CNT_W'(1);
            end
        end
    end

    AST_NP_ERR_ON_RESET: assert property (@(posedge hclk) disable iff (!hresetn)
        (sec_reset_active && np_count != '0) |=> np_err_rsp)
        else $error("Outstanding nonposted request not answered with error");

endmodule

//--- core/sideband_sequencer.sv
// Sideband reset and power-management sequencer with an AHB-Lite register port.
// Assumes all sideband pins are asynchronous and externally pulled up;
// the outside world resolves each open-drain pin from its enable.
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
// Function
// - Power loss and reset override link halt
// - Sample power-good and reset; optional open-drain pull
// - Debounce all slow sideband inputs before use; the synchronised, undebounced chain reset also gates link enable and wake
// - Wake request is open-drain wired-OR
// - Sideband skew stays within per-signal limits
// - Tolerate power-good skew up to 200us
// - Bridge has separate secondary pins it drives
// - Bridge forwards primary downstream, never upstream
// - Secondary reset errors all outstanding nonposted requests
// - Host bridge drives and samples chain pair
// - Host reset propagates onto chain reset
// - Ignore inputs faster than input synchronisation
// - Power loss during reset means cold reset
module sideband_sequencer
    import sideband_pkg::*;
(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              power_good_in,
    output logic                   power_good_out,
    output logic                   power_good_oe,
    input  wire logic              chain_reset_n_in,
    output logic                   chain_reset_n_out,
    output logic                   chain_reset_n_oe,
    input  wire logic              link_halt_n_in,
    input  wire logic              link_wake_req_n_in,
    output logic                   link_wake_req_n_out,
    output logic                   link_wake_req_n_oe,
    input  wire logic              host_reset_n_in,
    output logic                   sec_power_good_out,
    output logic                   sec_power_good_oe,
    output logic                   sec_chain_reset_n_out,
    output logic                   sec_chain_reset_n_oe,
    input  wire logic              np_issue,
    input  wire logic              np_done,
    output logic                   np_err_rsp,
    output logic                   link_enable
);

    logic                  pg_clean;
    logic                  rst_n_clean;
    logic                  rst_n_fast;
    logic                  halt_n_clean;
    logic                  wake_n_clean;
    logic                  host_rst_n_clean;
    logic [CTRL_W-1:0]     ctrl_reg;
    link_state_type        state_reg;
    link_state_type        state_next;
    logic                  cold_reg;
    logic                  order_err_reg;
    logic                  short_halt_reg;
    logic [CNT_W-1:0]      halt_cnt_reg;
    logic                  halt_prev_reg;
    logic                  sec_reset_active;
    logic [CNT_W-1:0]      np_count;
    logic                  wr_pend_reg;
    logic [31:0]           wr_addr_reg;
    logic                  addr_phase;
    logic                  order_err_set;
    logic                  short_halt_set;

    sideband_filter #(.RESET_VAL(1'b0)) pg_filter (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .pin_in    (power_good_in),
        .fast_out  (),
        .clean_out (pg_clean)
    );

    sideband_filter #(.RESET_VAL(1'b0)) rst_filter (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .pin_in    (chain_reset_n_in),
        .fast_out  (rst_n_fast),
        .clean_out (rst_n_clean)
    );

    sideband_filter #(.RESET_VAL(1'b1)) halt_filter (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .pin_in    (link_halt_n_in),
        .fast_out  (),
        .clean_out (halt_n_clean)
    );

    sideband_filter #(.RESET_VAL(1'b1)) wake_filter (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .pin_in    (link_wake_req_n_in),
        .fast_out  (),
        .clean_out (wake_n_clean)
    );

    sideband_filter #(.RESET_VAL(1'b0)) host_filter (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .pin_in    (host_reset_n_in),
        .fast_out  (),
        .clean_out (host_rst_n_clean)
    );

    np_error_drain np_drain (
        .hclk             (hclk),
        .hresetn          (hresetn),
        .sec_reset_active (sec_reset_active),
        .np_issue         (np_issue),
        .np_done          (np_done),
        .np_err_rsp       (np_err_rsp),
        .np_count         (np_count)
    );

    // Power loss first, then reset, then halt
    always_comb begin
        if (!pg_clean) begin
            state_next = COLD_RESET;
        end else if (!rst_n_clean) begin
            state_next = (state_reg == COLD_RESET) ? COLD_RESET : WARM_RESET;
        end else if (!halt_n_clean) begin
            state_next = HALTED;
        end else begin
            state_next = ACTIVE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= COLD_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Remembers the kind of the last reset until the next one starts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cold_reg <= 1'b1;
        end else if (state_next == COLD_RESET) begin
            cold_reg <= 1'b1;
        end else if (state_next == WARM_RESET && state_reg != WARM_RESET) begin
            cold_reg <= 1'b0;
        end
    end

    // Halt still low when a warm reset releases breaks the release order
    assign order_err_set  = rst_n_clean && !halt_prev_reg && !halt_n_clean
                            && state_reg == WARM_RESET;
    assign short_halt_set = halt_n_clean && !halt_prev_reg
                            && halt_cnt_reg < CNT_W'(HALT_MIN_CYCLES);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            halt_prev_reg <= 1'b1;
            halt_cnt_reg  <= '0;
        end else begin
            halt_prev_reg <= halt_n_clean;
            if (halt_n_clean) begin
                halt_cnt_reg <= '0;
            end else if (halt_cnt_reg != '1) begin
                halt_cnt_reg <= halt_cnt_reg + CNT_W'(1);
            end
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            order_err_reg  <= 1'b0;
            short_halt_reg <= 1'b0;
        end else begin
            if (order_err_set) begin
                order_err_reg <= 1'b1;
            end else if (wr_pend_reg && wr_addr_reg == STATUS_ADDR && hwdata[ST_ORDER_ERR]) begin
                order_err_reg <= 1'b0;
            end
            if (short_halt_set) begin
                short_halt_reg <= 1'b1;
            end else if (wr_pend_reg && wr_addr_reg == STATUS_ADDR && hwdata[ST_SHORT_HALT]) begin
                short_halt_reg <= 1'b0;
            end
        end
    end

    // AHB-Lite slave, zero wait states, always OKAY
    assign addr_phase = hsel && hready && htrans[1];
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 32'h0000_0000;
        end else begin
            wr_pend_reg <= addr_phase && hwrite;
            wr_addr_reg <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_pend_reg && wr_addr_reg == CTRL_ADDR) begin
            ctrl_reg <= hwdata[CTRL_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            if (haddr == CTRL_ADDR) begin
                hrdata <= {26'h000_0000, ctrl_reg};
            end else if (haddr == STATUS_ADDR) begin
                hrdata <= {21'h00_0000, short_halt_reg, order_err_reg, cold_reg, 2'h0,
                           state_reg, wake_n_clean, halt_n_clean, rst_n_clean, pg_clean};
            end else if (haddr == NP_COUNT_ADDR) begin
                hrdata <= {24'h00_0000, np_count};
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    // Primary pair: pulled only by software or host reset, never by the secondary
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chain_reset_n_oe <= 1'b0;
            power_good_oe    <= 1'b0;
        end else begin
            chain_reset_n_oe <= (ctrl_reg[CTRL_OD_EN] || ctrl_reg[CTRL_HOST_MODE])
                                && (ctrl_reg[CTRL_SW_CHAIN]
                                    || (ctrl_reg[CTRL_HOST_MODE] && !host_rst_n_clean));
            power_good_oe    <= ctrl_reg[CTRL_HOST_MODE] && !host_rst_n_clean;
        end
    end

    assign chain_reset_n_out = 1'b0;
    assign power_good_out    = 1'b0;

    // Secondary pair copies the primary downward only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sec_chain_reset_n_oe <= 1'b1;
            sec_power_good_oe    <= 1'b1;
            sec_reset_active     <= 1'b1;
        end else begin
            sec_chain_reset_n_oe <= ctrl_reg[CTRL_BRIDGE]
                                    && (!rst_n_clean || ctrl_reg[CTRL_SW_SEC]);
            sec_power_good_oe    <= ctrl_reg[CTRL_BRIDGE] && !pg_clean;
            sec_reset_active     <= ctrl_reg[CTRL_BRIDGE]
                                    && (!rst_n_clean || !pg_clean || ctrl_reg[CTRL_SW_SEC]);
        end
    end

    assign sec_chain_reset_n_out = 1'b0;
    assign sec_power_good_out    = 1'b0;

    // The raw synchronised reset cuts the wake pull two cycles before the filter would
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_wake_req_n_oe <= 1'b0;
            link_enable        <= 1'b0;
        end else begin
            link_wake_req_n_oe <= ctrl_reg[CTRL_WAKE] && rst_n_fast && halt_n_clean
                                  && state_next == ACTIVE;
            link_enable        <= rst_n_fast && state_next == ACTIVE;
        end
    end

    assign link_wake_req_n_out = 1'b0;

    AST_COLD_PRIORITY: assert property (@(posedge hclk) disable iff (!hresetn)
        !pg_clean |=> state_reg == COLD_RESET)
        else $error("Power loss did not force cold reset");

    AST_RESET_OVER_HALT: assert property (@(posedge hclk) disable iff (!hresetn)
        (!rst_n_clean && !halt_n_clean) |=> state_reg != HALTED && !link_enable)
        else $error("Halt took precedence over reset");

    AST_WARM_KEEPS_COLD: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_reg == COLD_RESET && pg_clean && !rst_n_clean) |=> state_reg == COLD_RESET)
        else $error("Cold reset turned warm while reset held");

    AST_WAKE_NOT_IN_HALT: assert property (@(posedge hclk) disable iff (!hresetn)
        link_wake_req_n_oe |-> $past(halt_n_clean) && $past(ctrl_reg[CTRL_WAKE]))
        else $error("Wake request pulled while halted or unrequested");

    AST_IGNORE_ON_RESET: assert property (@(posedge hclk) disable iff (!hresetn)
        !rst_n_fast |=> !link_enable && !link_wake_req_n_oe)
        else $error("Inputs not ignored after reset seen");

    AST_BRIDGE_FORWARD: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_reg[CTRL_BRIDGE] && !rst_n_clean) |=> sec_chain_reset_n_oe)
        else $error("Primary reset not forwarded to secondary");

    AST_HOST_PROPAGATE: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_reg[CTRL_HOST_MODE] && !host_rst_n_clean) |=> chain_reset_n_oe && power_good_oe)
        else $error("Host reset not driven onto chain pair");

    AST_NO_UPWARD_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn)
        chain_reset_n_oe |-> $past(ctrl_reg[CTRL_SW_CHAIN])
                             || !$past(host_rst_n_clean))
        else $error("Primary reset pulled without a primary-side cause");

    AST_SHORT_HALT_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
        short_halt_set |=> short_halt_reg)
        else $error("Short halt not recorded");

    COV_WARM_RESET: cover property (@(posedge hclk) disable iff (!hresetn)
        state_reg == WARM_RESET ##1 state_reg == ACTIVE);
    COV_HALT_CYCLE: cover property (@(posedge hclk) disable iff (!hresetn)
        state_reg == ACTIVE ##1 state_reg == HALTED ##[1:50] state_reg == ACTIVE);
    COV_NP_DRAIN: cover property (@(posedge hclk) disable iff (!hresetn)
        np_err_rsp ##1 np_err_rsp);
    COV_WAKE: cover property (@(posedge hclk) disable iff (!hresetn) link_wake_req_n_oe);

endmodule

//--- testbench/sideband_far_end.sv
// Behavioural far side of the sideband pins: system reset logic and the chain's halt source.
// Assumes pull-ups on every pin and that the device only ever pulls a line low.
`timescale 1ns/10ps
module sideband_far_end
    import sideband_pkg::*;
(
    input  wire logic hclk,
    input  wire logic sys_pg,
    input  wire logic sys_rst_n,
    input  wire logic sys_halt_n,
    input  wire logic sys_wake_n,
    input  wire logic allow_short,
    input  wire logic pg_oe,
    input  wire logic rst_oe,
    input  wire logic wake_oe,
    output logic      pg_pin,
    output logic      rst_n_pin,
    output logic      halt_n_pin,
    output logic      wake_n_pin
);
    logic       halt_reg = 1'b0;
    logic       rst_reg  = 1'b1;
    logic [7:0] hold_cnt = 8'h00;

    // Margin of four cycles covers the device's own input synchroniser
    always_ff @(posedge hclk) begin
        if (!sys_halt_n) begin
            halt_reg <= 1'b1;
        end else if (allow_short || hold_cnt >= 8'(HALT_MIN_CYCLES + 4)) begin
            halt_reg <= 1'b0;
        end
    end

    always_ff @(posedge hclk) begin
        if (!halt_reg) begin
            hold_cnt <= 8'h00;
        end else if (hold_cnt != 8'hFF) begin
            hold_cnt <= hold_cnt + 8'h01;
        end
    end

    // Reset release waits until halt has been let go
    always_ff @(posedge hclk) begin
        if (!sys_rst_n) begin
            rst_reg <= 1'b0;
        end else if (!halt_reg) begin
            rst_reg <= 1'b1;
        end
    end

    // One shared wire per signal: no skew, so no skew exception is ever leaned on
    assign pg_pin     = sys_pg & ~pg_oe;
    assign rst_n_pin  = rst_reg & ~rst_oe;
    assign halt_n_pin = ~halt_reg;
    assign wake_n_pin = sys_wake_n & ~wake_oe;
endmodule

//--- testbench/testbench.sv
// Self-checking bench: AHB-Lite register tasks plus the far-side pin model.
// Assumes a single hclk domain and the register map of sideband_pkg.
`timescale 1ns/10ps
module testbench import sideband_pkg::*;;
    logic        hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize  = 3'b010;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
    logic        host_reset_n = 1'b1, np_issue = 1'b0, np_done = 1'b0, np_err_rsp, link_enable;
    logic        sys_pg = 1'b0, sys_rst_n = 1'b0, sys_halt_n = 1'b1, sys_wake_n = 1'b1;
    logic        allow_short = 1'b0, pg_pin, rst_n_pin, halt_n_pin, wake_n_pin;
    logic        power_good_out, power_good_oe, chain_reset_n_out, chain_reset_n_oe;
    logic        link_wake_req_n_out, link_wake_req_n_oe, sec_power_good_out;
    logic        sec_power_good_oe, sec_chain_reset_n_out, sec_chain_reset_n_oe;
    int          fails = 0, checks_done = 0, errs;

    sideband_sequencer i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .power_good_in(pg_pin),
        .power_good_out(power_good_out), .power_good_oe(power_good_oe),
        .chain_reset_n_in(rst_n_pin), .chain_reset_n_out(chain_reset_n_out),
        .chain_reset_n_oe(chain_reset_n_oe), .link_halt_n_in(halt_n_pin),
        .link_wake_req_n_in(wake_n_pin), .link_wake_req_n_out(link_wake_req_n_out),
        .link_wake_req_n_oe(link_wake_req_n_oe), .host_reset_n_in(host_reset_n),
        .sec_power_good_out(sec_power_good_out), .sec_power_good_oe(sec_power_good_oe),
        .sec_chain_reset_n_out(sec_chain_reset_n_out),
        .sec_chain_reset_n_oe(sec_chain_reset_n_oe), .np_issue(np_issue),
        .np_done(np_done), .np_err_rsp(np_err_rsp), .link_enable(link_enable)
    );

    sideband_far_end i_far (
        .hclk(hclk), .sys_pg(sys_pg), .sys_rst_n(sys_rst_n), .sys_halt_n(sys_halt_n),
        .sys_wake_n(sys_wake_n), .allow_short(allow_short), .pg_oe(power_good_oe),
        .rst_oe(chain_reset_n_oe), .wake_oe(link_wake_req_n_oe), .pg_pin(pg_pin),
        .rst_n_pin(rst_n_pin), .halt_n_pin(halt_n_pin), .wake_n_pin(wake_n_pin)
    );

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic rc(input logic [31:0] a, m, e, input string n);
        bus(1'b0, a, 32'h0);
        chk(n, e, d & m);
    endtask

    task automatic done(input string n);
        $display("test %s finished", n);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    initial begin
        cyc(5000);
        fails++;
        final_report();
    end

    initial begin
        cyc(8);
        chk("sec_rst_oe", 32'h1, sec_chain_reset_n_oe);
        hresetn <= 1'b1;
        rc(CTRL_ADDR, 32'hFFFF_FFFF, 32'h0, "ctrl");
        rc(NP_COUNT_ADDR, 32'hFFFF_FFFF, 32'h0, "np_count");
        bus(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
        rc(32'h0000_0040, 32'hFFFF_FFFF, 32'h0, "unmapped");
        bus(1'b1, CTRL_ADDR, 32'hFFFF_FFE0);
        rc(CTRL_ADDR, 32'hFFFF_FFFF, 32'h20, "ctrl");
        done("registers");
        cyc(2);
        chk("sec_pg_oe", 32'h1, sec_power_good_oe);
        sys_pg <= 1'b1;
        cyc(8);
        chk("sec_pg_oe", 32'h0, sec_power_good_oe);
        chk("sec_rst_oe", 32'h1, sec_chain_reset_n_oe);
        sys_rst_n <= 1'b1;
        cyc(8);
        chk("sec_rst_oe", 32'h0, sec_chain_reset_n_oe);
        rc(STATUS_ADDR, 32'h133, 32'h133, "status");
        sys_halt_n <= 1'b0;
        sys_rst_n  <= 1'b0;
        cyc(8);
        chk("link_enable", 32'h0, link_enable);
        chk("sec_rst_oe", 32'h1, sec_chain_reset_n_oe);
        rc(STATUS_ADDR, 32'h130, 32'h10, "status");
        sys_halt_n <= 1'b1;
        sys_rst_n  <= 1'b1;
        cyc(40);
        rc(STATUS_ADDR, 32'h230, 32'h30, "status");
        done("reset");
        sys_halt_n <= 1'b0;
        cyc(8);
        rc(STATUS_ADDR, 32'h34, 32'h20, "status");
        chk("link_enable", 32'h0, link_enable);
        sys_halt_n <= 1'b1;
        cyc(40);
        rc(STATUS_ADDR, 32'h434, 32'h34, "status");
        allow_short <= 1'b1;
        sys_halt_n  <= 1'b0;
        cyc(6);
        sys_halt_n <= 1'b1;
        cyc(8);
        rc(STATUS_ADDR, 32'h400, 32'h400, "status");
        bus(1'b1, STATUS_ADDR, 32'h0000_0400);
        rc(STATUS_ADDR, 32'h400, 32'h0, "status");
        // A one-cycle blip must never reach the state logic
        sys_halt_n <= 1'b0;
        cyc(1);
        sys_halt_n <= 1'b1;
        cyc(8);
        chk("link_enable", 32'h1, link_enable);
        rc(STATUS_ADDR, 32'h434, 32'h34, "status");
        allow_short <= 1'b0;
        done("halt");
        bus(1'b1, CTRL_ADDR, 32'h08);
        host_reset_n <= 1'b0;
        cyc(10);
        chk("rst_oe", 32'h1, chain_reset_n_oe);
        chk("pg_oe", 32'h1, power_good_oe);
        chk("rst_out", 32'h0, chain_reset_n_out);
        chk("pg_out", 32'h0, power_good_out);
        rc(STATUS_ADDR, 32'h103, 32'h100, "status");
        host_reset_n <= 1'b1;
        cyc(8);
        chk("rst_oe", 32'h0, chain_reset_n_oe);
        chk("pg_oe", 32'h0, power_good_oe);
        bus(1'b1, CTRL_ADDR, 32'h09);
        cyc(8);
        chk("rst_oe", 32'h1, chain_reset_n_oe);
        chk("pg_oe", 32'h0, power_good_oe);
        rc(STATUS_ADDR, 32'h133, 32'h11, "status");
        bus(1'b1, CTRL_ADDR, 32'h01);
        cyc(2);
        chk("rst_oe", 32'h0, chain_reset_n_oe);
        bus(1'b1, CTRL_ADDR, 32'h11);
        cyc(2);
        chk("rst_oe", 32'h1, chain_reset_n_oe);
        bus(1'b1, CTRL_ADDR, 32'h00);
        cyc(40);
        done("host");
        sys_wake_n <= 1'b0;
        cyc(8);
        rc(STATUS_ADDR, 32'h8, 32'h0, "status");
        chk("wake_oe", 32'h0, link_wake_req_n_oe);
        sys_wake_n <= 1'b1;
        bus(1'b1, CTRL_ADDR, 32'h04);
        cyc(2);
        chk("wake_oe", 32'h1, link_wake_req_n_oe);
        chk("wake_out", 32'h0, link_wake_req_n_out);
        sys_rst_n <= 1'b0;
        cyc(8);
        chk("wake_oe", 32'h0, link_wake_req_n_oe);
        sys_rst_n <= 1'b1;
        cyc(8);
        chk("wake_oe", 32'h1, link_wake_req_n_oe);
        bus(1'b1, CTRL_ADDR, 32'h20);
        done("wake");
        repeat (3) begin
            np_issue <= 1'b1;
            cyc(1);
            np_issue <= 1'b0;
            cyc(1);
        end
        np_done <= 1'b1;
        cyc(1);
        np_done <= 1'b0;
        rc(NP_COUNT_ADDR, 32'hFF, 32'h2, "np_count");
        errs = 0;
        bus(1'b1, CTRL_ADDR, 32'h22);
        repeat (10) begin
            cyc(1);
            errs += int'(np_err_rsp === 1'b1);
        end
        chk("np_err", 32'h2, errs);
        np_issue <= 1'b1;
        cyc(1);
        np_issue <= 1'b0;
        rc(NP_COUNT_ADDR, 32'hFF, 32'h0, "np_count");
        chk("sec_rst_oe", 32'h1, sec_chain_reset_n_oe);
        chk("sec_rst_out", 32'h0, sec_chain_reset_n_out);
        chk("sec_pg_out", 32'h0, sec_power_good_out);
        done("nonposted");
        final_report();
    end
endmodule
